// ==== verilog/pse_pkg.sv ====
// Package: register map, field positions and reset values of the status and event flag block
// Contract
// - Bit7 boost fault-free, bit6 buck power-good
// - Charge state bits 5:4; bits 3:2 reserved
// - Power-cycled bit1, cleared after read
// - Bit0 follows mode pin, resets zero
// - Input register bit5 system-rail undervolt; 7:6 reserved
// - Input register bit4 input current limit
// - Input bits 3..0: DPM, recover, undervolt, overvolt
// - Battery bits 7..4: hot, warm, cool, cold
// - Battery bits 3..1: short, overcurrent, power-path
// - Battery bit0 undervolt lockout, resets zero
package pse_pkg;

  // Register bus widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [15:0] STATUS_SUMMARY_OFS   = 16'h0002;
  localparam logic [15:0] INPUT_SUPPLY_EVT_OFS = 16'h0003;
  localparam logic [15:0] BATTERY_EVT_OFS      = 16'h0004;

  // Status summary field positions
  localparam int unsigned BOOST_OK_BIT     = 7;
  localparam int unsigned BUCK_GOOD_BIT    = 6;
  localparam int unsigned CHARGE_STATE_LSB = 4;
  localparam int unsigned POWER_CYCLED_BIT = 1;
  localparam int unsigned MODE_PIN_BIT     = 0;

  // Input-supply event field positions
  localparam int unsigned SYS_RAIL_UV_BIT   = 5;
  localparam int unsigned INPUT_CUR_LIM_BIT = 4;
  localparam int unsigned INPUT_DYN_PWR_BIT = 3;
  localparam int unsigned INPUT_UV_RCV_BIT  = 2;
  localparam int unsigned INPUT_UV_BIT      = 1;
  localparam int unsigned INPUT_OV_BIT      = 0;

  // Battery event field positions
  localparam int unsigned BATT_HOT_BIT      = 7;
  localparam int unsigned BATT_WARM_BIT     = 6;
  localparam int unsigned BATT_COOL_BIT     = 5;
  localparam int unsigned BATT_COLD_BIT     = 4;
  localparam int unsigned BATT_SHORT_BIT    = 3;
  localparam int unsigned BATT_OVERCUR_BIT  = 2;
  localparam int unsigned BATT_PWR_PATH_BIT = 1;
  localparam int unsigned BATT_UV_BIT       = 0;

  // Charge state encodings
  localparam logic [1:0] CHARGE_READY       = 2'h0;
  localparam logic [1:0] CHARGE_IN_PROGRESS = 2'h1;
  localparam logic [1:0] CHARGE_DONE        = 2'h2;
  localparam logic [1:0] CHARGE_FAULT       = 2'h3;

  // Event register widths and usable-bit masks
  localparam int unsigned INPUT_EVT_W = 6;
  localparam int unsigned BATT_EVT_W  = 8;
  localparam logic [7:0]  INPUT_EVT_MASK = 8'h3f;
  localparam logic [7:0]  BATT_EVT_MASK  = 8'hff;

  // Reset values
  localparam logic [7:0] STATUS_SUMMARY_RST = 8'h00;
  localparam logic [7:0] EVENT_RST          = 8'h00;

endpackage

// ==== verilog/pse_sticky_flags.sv ====
// Sticky event flags: set by a level, cleared by the host, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module pse_sticky_flags #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Event sources and clear
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  // Latched flags
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } pse_sticky_state_t;

  pse_sticky_state_t st_q;
  pse_sticky_state_t st_d;

  // Hold until cleared; a fresh event in the clearing cycle survives
  always_comb
  begin
    st_d       = st_q;
    st_d.flags = (st_q.flags & ~clr_in) | set_in;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign flags = st_q.flags;

endmodule
`default_nettype wire

// ==== verilog/pse_status_event_flags.sv ====
// Status summary and event flag registers read and cleared by the host
`timescale 1ns/10ps
`default_nettype none
module pse_status_event_flags
  import pse_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Register access port (one access per strobe)
  input  wire logic [pse_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic                        reg_rd,
  input  wire logic                        reg_wr,
  input  wire logic [pse_pkg::DATA_W-1:0]  reg_wdata,
  output logic      [pse_pkg::DATA_W-1:0]  reg_rdata,
  output logic                             reg_rvalid,
  // Live status sources
  input  wire logic                        boost_ok,
  input  wire logic                        buck_good,
  input  wire logic [1:0]                  charge_state,
  input  wire logic                        mode_pin,
  input  wire logic                        power_cycle_event,
  // Input-supply and system-rail event sources
  input  wire logic                        sys_rail_undervolt_event,
  input  wire logic                        input_current_limit_event,
  input  wire logic                        input_dyn_power_event,
  input  wire logic                        input_undervolt_recover_event,
  input  wire logic                        input_undervolt_event,
  input  wire logic                        input_overvolt_event,
  // Battery event sources
  input  wire logic                        batt_hot_event,
  input  wire logic                        batt_warm_event,
  input  wire logic                        batt_cool_event,
  input  wire logic                        batt_cold_event,
  input  wire logic                        batt_short_event,
  input  wire logic                        batt_overcurrent_event,
  input  wire logic                        batt_power_path_event,
  input  wire logic                        batt_undervolt_event,
  // Flag register copies for on-chip use
  output logic [pse_pkg::DATA_W-1:0]       status_summary,
  output logic [pse_pkg::DATA_W-1:0]       input_supply_event_flags,
  output logic [pse_pkg::DATA_W-1:0]       battery_event_flags
);

  import pse_pkg::*;

  typedef struct packed {
    logic              boost_ok_flag;
    logic              buck_good_flag;
    logic [1:0]        charge_state_field;
    logic              mode_pin_level;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } pse_main_state_t;

  pse_main_state_t st_q;
  pse_main_state_t st_d;

  // Flag plumbing, register images and address hits
  logic [INPUT_EVT_W-1:0] input_set;
  logic [INPUT_EVT_W-1:0] input_clr;
  logic [INPUT_EVT_W-1:0] input_flags;
  logic [BATT_EVT_W-1:0]  batt_set;
  logic [BATT_EVT_W-1:0]  batt_clr;
  logic [BATT_EVT_W-1:0]  batt_flags;
  logic                   pwr_clr;
  logic                   pwr_flag;
  logic [DATA_W-1:0]      status_word;
  logic [DATA_W-1:0]      input_word;
  logic [DATA_W-1:0]      batt_word;
  logic [DATA_W-1:0]      rd_word;
  logic                   hit_status;
  logic                   hit_input;
  logic                   hit_batt;

  // Address decode
  assign hit_status = (reg_addr == STATUS_SUMMARY_OFS);
  assign hit_input  = (reg_addr == INPUT_SUPPLY_EVT_OFS);
  assign hit_batt   = (reg_addr == BATTERY_EVT_OFS);

  // Input-supply event sources at their register bit positions
  always_comb
  begin
    input_set                    = '0;
    input_set[SYS_RAIL_UV_BIT]   = sys_rail_undervolt_event;
    input_set[INPUT_CUR_LIM_BIT] = input_current_limit_event;
    input_set[INPUT_DYN_PWR_BIT] = input_dyn_power_event;
    input_set[INPUT_UV_RCV_BIT]  = input_undervolt_recover_event;
    input_set[INPUT_UV_BIT]      = input_undervolt_event;
    input_set[INPUT_OV_BIT]      = input_overvolt_event;
  end

  // Battery event sources at their register bit positions
  always_comb
  begin
    batt_set                     = '0;
    batt_set[BATT_HOT_BIT]       = batt_hot_event;
    batt_set[BATT_WARM_BIT]      = batt_warm_event;
    batt_set[BATT_COOL_BIT]      = batt_cool_event;
    batt_set[BATT_COLD_BIT]      = batt_cold_event;
    batt_set[BATT_SHORT_BIT]     = batt_short_event;
    batt_set[BATT_OVERCUR_BIT]   = batt_overcurrent_event;
    batt_set[BATT_PWR_PATH_BIT]  = batt_power_path_event;
    batt_set[BATT_UV_BIT]        = batt_undervolt_event;
  end

  // Write-one-to-clear; the summary and reserved bits have no flop to hit,
  // so a write there is dropped without side effects
  always_comb
  begin
    input_clr = '0;
    batt_clr  = '0;
    if (reg_wr)
    begin
      case (1'b1)
        hit_input: input_clr = reg_wdata[INPUT_EVT_W-1:0];
        hit_batt:  batt_clr  = reg_wdata[BATT_EVT_W-1:0];
        default:   input_clr = '0;
      endcase
    end
  end

  // Reading the summary clears the power-cycled bit after its value is taken
  // A fresh power cycle in the reading cycle wins, so it is never lost
  assign pwr_clr = reg_rd && hit_status;

  // Input-supply flags: six used bits only
  pse_sticky_flags #(
    .WIDTH (INPUT_EVT_W)
  ) u_input_flags (
    .clk    (clk),
    .nrst   (nrst),
    .set_in (input_set),
    .clr_in (input_clr),
    .flags  (input_flags)
  );

  // Battery flags: all eight bits used
  pse_sticky_flags #(
    .WIDTH (BATT_EVT_W)
  ) u_batt_flags (
    .clk    (clk),
    .nrst   (nrst),
    .set_in (batt_set),
    .clr_in (batt_clr),
    .flags  (batt_flags)
  );

  // Power-cycled flag, cleared by a summary read instead of a write
  pse_sticky_flags #(
    .WIDTH (1)
  ) u_pwr_cycled (
    .clk    (clk),
    .nrst   (nrst),
    .set_in (power_cycle_event),
    .clr_in (pwr_clr),
    .flags  (pwr_flag)
  );

  // Assemble the register images from flops only
  always_comb
  begin
    status_word                              = STATUS_SUMMARY_RST;
    status_word[BOOST_OK_BIT]                = st_q.boost_ok_flag;
    status_word[BUCK_GOOD_BIT]               = st_q.buck_good_flag;
    status_word[CHARGE_STATE_LSB+1 -: 2]     = st_q.charge_state_field;
    status_word[POWER_CYCLED_BIT]            = pwr_flag;
    status_word[MODE_PIN_BIT]                = st_q.mode_pin_level;
    status_word[CHARGE_STATE_LSB-1 -: 2]     = 2'h0;
  end

  // Event images; only flop bits reach the host, reserved bits stay zero
  always_comb
  begin
    input_word                               = EVENT_RST;
    input_word[INPUT_EVT_W-1:0]              = input_flags;
    input_word                               = input_word & INPUT_EVT_MASK;
    batt_word                                = batt_flags & BATT_EVT_MASK;
  end

  // Sample live status each cycle; answer reads one cycle later
  always_comb
  begin
    st_d                    = st_q;
    st_d.boost_ok_flag      = boost_ok;
    st_d.buck_good_flag     = buck_good;
    st_d.charge_state_field = charge_state;
    st_d.mode_pin_level     = mode_pin;
    st_d.rvalid             = reg_rd;
    if (reg_rd)
      st_d.rdata = rd_word; // Held between reads
  end

  // Read mux; unmapped offsets read zero rather than stale data
  always_comb
  begin
    case (1'b1)
      hit_status: rd_word = status_word;
      hit_input:  rd_word = input_word;
      hit_batt:   rd_word = batt_word;
      default:    rd_word = '0;
    endcase
  end

  // Single state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Read port from flops; images are flop bits and constant zeros
  assign reg_rdata                = st_q.rdata;
  assign reg_rvalid               = st_q.rvalid;
  assign status_summary           = status_word;
  assign input_supply_event_flags = input_word;
  assign battery_event_flags      = batt_word;

endmodule
`default_nettype wire

// ==== testbench/pse_sef_props.sv ====
// Checker of status image timing and event flag latching
`timescale 1ns/10ps
`default_nettype none
module pse_sef_props
  import pse_pkg::*;
(
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  // Sources and register images
  input wire logic        boost_ok,
  input wire logic        buck_good,
  input wire logic [1:0]  charge_state,
  input wire logic        mode_pin,
  input wire logic        power_cycle_event,
  input wire logic        input_overvolt_event,
  input wire logic        batt_hot_event,
  input wire logic [7:0]  status_summary,
  input wire logic [7:0]  input_supply_event_flags,
  input wire logic [7:0]  battery_event_flags
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Live status bits lag their sources by one edge
  a_boost_live: assert property (1'b1 |=> status_summary[7] == $past(boost_ok)) else $error("boost bit wrong");
  a_buck_live: assert property (1'b1 |=> status_summary[6] == $past(buck_good)) else $error("buck bit wrong");
  a_charge_live: assert property (1'b1 |=> status_summary[5:4] == $past(charge_state)) else $error("charge wrong");
  a_mode_live: assert property (1'b1 |=> status_summary[0] == $past(mode_pin)) else $error("mode bit wrong");
  a_resv_zero: assert property (status_summary[3:2] == 2'h0 && input_supply_event_flags[7:6] == 2'h0)
    else $error("reserved bits set");
  // Any read of the summary drops the power-cycled bit unless it is re-set
  a_pcyc_clear: assert property (reg_rd && reg_addr == STATUS_SUMMARY_OFS && !power_cycle_event
    |=> !status_summary[1]) else $error("power-cycled bit kept");
  a_ovp_latch: assert property (input_overvolt_event |=> input_supply_event_flags[0]) else $error("ovp lost");
  a_hot_latch: assert property (batt_hot_event |=> battery_event_flags[7]) else $error("hot lost");
  // Without a write to its own event register (battery or input) no flag may fall
  a_flag_hold: assert property (!(reg_wr && reg_addr == BATTERY_EVT_OFS)
    |=> ($past(battery_event_flags) & ~battery_event_flags) == 8'h00) else $error("flag fell");
  a_input_hold: assert property (!(reg_wr && reg_addr == INPUT_SUPPLY_EVT_OFS)
    |=> ($past(input_supply_event_flags) & ~input_supply_event_flags) == 8'h00) else $error("input flag fell");
  cover property (reg_rd && reg_addr == STATUS_SUMMARY_OFS && status_summary[1]);
  cover property (reg_wr && reg_addr == INPUT_SUPPLY_EVT_OFS && input_supply_event_flags != 8'h00);
  cover property (battery_event_flags == 8'h80);
endmodule
bind pse_status_event_flags pse_sef_props pse_sef_props_i (.*);
`default_nettype wire

// ==== testbench/pse_sef_host.sv ====
// Host model issuing register reads and writes on the strobe port
`timescale 1ns/10ps
`default_nettype none
module pse_sef_host (
  // Clock and answer
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  // Requests
  output logic     [15:0] reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  initial {reg_addr, reg_rd, reg_wr, reg_wdata} = '0;
  // Released lines show the inverse so a stale value cannot pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask
  // Answer stands one cycle; a missing answer returns unknown
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) {reg_rd, reg_addr} <= {1'b0, ~a};
    @(posedge clk) d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_pse_status_event_flags.sv ====
// Self-checking bench of the status and event flag registers
`timescale 1ns/10ps
`default_nettype none
module tb_pse_status_event_flags;
  import pse_pkg::*;
  logic       clk = 0, nrst = 0, bo = 0, bg = 0, mp = 0, pc = 0, rv;
  logic [1:0] cs = 0;
  logic [5:0] inp = 0;
  logic [7:0] bat = 0, rdat, d;
  logic [15:0] ad;
  logic       rs, ws;
  logic [7:0] wd;
  int         err_total = 0, checks = 0, cyc = 0;
  // Summary, both event registers and one unmapped place
  logic [15:0] ad_tbl [4] = '{STATUS_SUMMARY_OFS, INPUT_SUPPLY_EVT_OFS, BATTERY_EVT_OFS, 16'h0010};
  always #2 clk = ~clk;
  pse_sef_host pse_sef_host_i (.clk(clk), .reg_rdata(rdat), .reg_rvalid(rv), .reg_addr(ad), .reg_rd(rs),
    .reg_wr(ws), .reg_wdata(wd));
  pse_status_event_flags pse_status_event_flags_i (.clk(clk), .nrst(nrst), .reg_addr(ad), .reg_rd(rs),
    .reg_wr(ws), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .boost_ok(bo), .buck_good(bg),
    .charge_state(cs), .mode_pin(mp), .power_cycle_event(pc), .sys_rail_undervolt_event(inp[5]),
    .input_current_limit_event(inp[4]), .input_dyn_power_event(inp[3]),
    .input_undervolt_recover_event(inp[2]), .input_undervolt_event(inp[1]), .input_overvolt_event(inp[0]),
    .batt_hot_event(bat[7]), .batt_warm_event(bat[6]), .batt_cool_event(bat[5]), .batt_cold_event(bat[4]),
    .batt_short_event(bat[3]), .batt_overcurrent_event(bat[2]), .batt_power_path_event(bat[1]),
    .batt_undervolt_event(bat[0]), .status_summary(), .input_supply_event_flags(), .battery_event_flags());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end
  // One-cycle event pulse, then each flag is read, cleared and read again
  task automatic ev(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk)
      if (a == BATTERY_EVT_OFS)
        bat[i] <= 1'b1;
      else
        inp[i] <= 1'b1;
      @(posedge clk) {bat, inp} <= '0;
      repeat (2) @(posedge clk);
      pse_sef_host_i.rd(a, d); chk(d, 8'h01 << i);
      pse_sef_host_i.wr(a, 8'h01 << i);
      pse_sef_host_i.rd(a, d); chk(d, 8'h00);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (ad_tbl[k])
    begin
      pse_sef_host_i.rd(ad_tbl[k], d); chk(d, 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) {bo, bg, cs, mp} <= {~i[1], i[0], i[1:0], ~i[0]};
      repeat (2) @(posedge clk);
      pse_sef_host_i.rd(STATUS_SUMMARY_OFS, d); chk(d, {~i[1], i[0], i[1:0], 3'h0, ~i[0]});
    end
    $display("test live status done");
    @(posedge clk) {bo, bg, cs, mp, pc} <= {5'h00, 1'b1};
    @(posedge clk) pc <= 1'b0;
    pse_sef_host_i.wr(STATUS_SUMMARY_OFS, 8'hff);
    pse_sef_host_i.rd(STATUS_SUMMARY_OFS, d); chk(d, 8'h02);
    pse_sef_host_i.rd(STATUS_SUMMARY_OFS, d); chk(d, 8'h00);
    $display("test power cycle done");
    ev(INPUT_SUPPLY_EVT_OFS, 6);
    pse_sef_host_i.wr(INPUT_SUPPLY_EVT_OFS, 8'hc0);
    pse_sef_host_i.rd(INPUT_SUPPLY_EVT_OFS, d); chk(d, 8'h00);
    $display("test input events done");
    ev(BATTERY_EVT_OFS, 8);
    // Source still high at the clearing edge, low after it: the flag must survive
    @(posedge clk) bat[3] <= 1'b1;
    pse_sef_host_i.wr(BATTERY_EVT_OFS, 8'h08);
    bat[3] <= 1'b0;
    pse_sef_host_i.rd(BATTERY_EVT_OFS, d); chk(d, 8'h08);
    pse_sef_host_i.wr(BATTERY_EVT_OFS, 8'h08);
    pse_sef_host_i.rd(BATTERY_EVT_OFS, d); chk(d, 8'h00);
    $display("test battery events done");
    wrap_up();
  end
endmodule
`default_nettype wire
